// file: core/csf_pkg.sv
// Shared constants for the control-structure field access block
package csf_pkg;
  // Register byte offsets (low byte of the bus address)
  localparam logic [7:0]  OFF_ENC_LO   = 8'h00;
  localparam logic [7:0]  OFF_ENC_HI   = 8'h04;
  localparam logic [7:0]  OFF_SRC_LO   = 8'h08;
  localparam logic [7:0]  OFF_SRC_HI   = 8'h0C;
  localparam logic [7:0]  OFF_CTRL     = 8'h10;
  localparam logic [7:0]  OFF_STATUS   = 8'h14;
  localparam logic [7:0]  OFF_RES_LO   = 8'h18;
  localparam logic [7:0]  OFF_RES_HI   = 8'h1C;
  localparam logic [7:0]  OFF_ERROR    = 8'h20;
  // Control register bits
  localparam int          CTRL_LONG    = 0;
  localparam int          CTRL_GO_RD   = 1;
  localparam int          CTRL_GO_WR   = 2;
  // Status register bits
  localparam int          STAT_BUSY    = 0;
  localparam int          STAT_FAIL    = 1;
  localparam int          STAT_DONE    = 2;
  localparam int          STAT_EXIT    = 3;
  // Encoding field positions
  localparam int          ENC_RSV_LSB  = 15;
  localparam int          ENC_W_MSB    = 14;
  localparam int          ENC_W_LSB    = 13;
  localparam int          ENC_RSV_BIT  = 12;
  localparam int          ENC_T_MSB    = 11;
  localparam int          ENC_T_LSB    = 10;
  localparam int          ENC_I_MSB    = 9;
  localparam int          ENC_I_LSB    = 1;
  localparam int          ENC_ACC_BIT  = 0;
  // Width codes
  localparam logic [1:0]  WID_16       = 2'h0;
  localparam logic [1:0]  WID_64       = 2'h1;
  localparam logic [1:0]  WID_32       = 2'h2;
  localparam logic [1:0]  WID_NAT      = 2'h3;
  // Type codes
  localparam logic [1:0]  TYP_CTRL     = 2'h0;
  localparam logic [1:0]  TYP_RO       = 2'h1;
  localparam logic [1:0]  TYP_GUEST    = 2'h2;
  localparam logic [1:0]  TYP_HOST     = 2'h3;
  // Index that names the instruction-error field among read-only 32-bit fields
  localparam logic [8:0]  IDX_ERRFIELD = 9'h000;
  // Reset values
  localparam logic [31:0] RST_WORD     = 32'h00000000;
  localparam logic [63:0] RST_DWORD    = 64'h0000000000000000;
  // Instruction-error codes
  localparam logic [31:0] ERR_NONE     = 32'h00000000;
  localparam logic [31:0] ERR_BAD_FLD  = 32'h0000000C;
  localparam logic [31:0] ERR_RD_ONLY  = 32'h0000000D;
  localparam logic [31:0] ERR_ENC_HIGH = 32'h0000000E;
endpackage : csf_pkg

// file: core/field_if.sv
// Carrier between the access control, the encoding decoder and the field store
`timescale 1ns/1ns
interface field_if #(
  parameter int AW = 7
);
  logic [31:0]   enc_lo;     // Encoding bits 31:0
  logic [31:0]   enc_hi;     // Encoding operand bits 63:32
  logic [63:0]   src;        // Write source operand
  logic          long_mode;  // 64-bit mode in force
  logic          is_write;   // Write access when high
  logic [31:0]   err_q;      // Current instruction-error field
  logic          we;         // Store write strobe
  logic [AW-1:0] addr;       // Store word address
  logic [63:0]   field_q;    // Stored field value
  logic [63:0]   rd_val;     // Destination value for a read
  logic [63:0]   wr_val;     // New field value for a write
  logic          fail;       // Access refused
  logic [31:0]   fail_code;  // Cause of refusal

  modport dec (input enc_lo, enc_hi, src, long_mode, is_write, err_q, field_q,
               output rd_val, wr_val, fail, fail_code, addr);
  modport store (input addr, we, wr_val, output field_q);
  modport top (output enc_lo, enc_hi, src, long_mode, is_write, err_q, we,
               input rd_val, fail, fail_code);
endinterface : field_if

// file: core/field_decoder.sv
// Encoding decoder and width/mode data steering for field reads and writes
`timescale 1ns/1ns
module field_decoder
  import csf_pkg::*;
#(
  parameter int IDX_W     = 3,
  parameter bit HAS_EXT64 = 1'b1
) (
  field_if.dec fif
);
  logic [1:0]  wcode;    // Field width
  logic [1:0]  tcode;    // Field type
  logic [8:0]  idx;      // Field index
  logic        high;     // High access
  logic        eff64;    // Field really holds 64 bits
  logic        err_sel;  // Encoding names the instruction-error field
  logic [63:0] fval;     // Field value seen by a read

  // Decode, check and steer
  always_comb begin
    wcode   = fif.enc_lo[ENC_W_MSB:ENC_W_LSB];
    tcode   = fif.enc_lo[ENC_T_MSB:ENC_T_LSB];
    idx     = fif.enc_lo[ENC_I_MSB:ENC_I_LSB];
    high    = fif.enc_lo[ENC_ACC_BIT];
    // Natural width follows the 64-bit extension
    eff64   = (wcode == WID_64) || ((wcode == WID_NAT) && HAS_EXT64);
    err_sel = (wcode == WID_32) && (tcode == TYP_RO) && (idx == IDX_ERRFIELD) && !high;
    fval    = err_sel ? {32'h00000000, fif.err_q} : fif.field_q;
    fif.addr      = {wcode, tcode, idx[IDX_W-1:0]};
    fif.fail      = 1'b0;
    fif.fail_code = ERR_NONE;
    // Refusals in priority order
    if (fif.long_mode && (fif.enc_hi != 32'h00000000)) begin
      fif.fail      = 1'b1;
      fif.fail_code = ERR_ENC_HIGH;
    end else if ((fif.enc_lo[31:ENC_RSV_LSB] != 17'h00000) || fif.enc_lo[ENC_RSV_BIT]) begin
      fif.fail      = 1'b1;
      fif.fail_code = ERR_BAD_FLD;
    end else if (high && (wcode != WID_64)) begin
      fif.fail      = 1'b1;
      fif.fail_code = ERR_BAD_FLD;
    end else if (((idx >> IDX_W) != 9'h000) && !err_sel) begin
      fif.fail      = 1'b1;
      fif.fail_code = ERR_BAD_FLD;
    end else if (fif.is_write && (tcode == TYP_RO)) begin
      fif.fail      = 1'b1;
      fif.fail_code = ERR_RD_ONLY;
    end
    // Steering by width, access type and mode
    if (wcode == WID_16) begin
      fif.rd_val = {48'h000000000000, fval[15:0]};
      fif.wr_val = {48'h000000000000, fif.src[15:0]};
    end else if (!eff64) begin
      fif.rd_val = {32'h00000000, fval[31:0]};
      fif.wr_val = {32'h00000000, fif.src[31:0]};
    end else if (high) begin
      fif.rd_val = {32'h00000000, fval[63:32]};
      fif.wr_val = {fif.src[31:0], fif.field_q[31:0]};
    end else if (fif.long_mode) begin
      fif.rd_val = fval;
      fif.wr_val = fif.src;
    end else begin
      fif.rd_val = {32'h00000000, fval[31:0]};
      fif.wr_val = {32'h00000000, fif.src[31:0]};
    end
  end
endmodule : field_decoder

// file: core/field_store.sv
// Field storage array, one 64-bit word per width, type and index
`timescale 1ns/1ns
module field_store
  import csf_pkg::*;
#(
  parameter int AW = 7
) (
  input wire logic clk,
  input wire logic rst,
  field_if.store   fif
);
  logic [63:0] mem [0:(1<<AW)-1];  // Field words

  // Clear on reset, write on strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < (1 << AW); i++) begin
        mem[i] <= RST_DWORD;
      end
    end else if (fif.we) begin
      mem[fif.addr] <= fif.wr_val;
    end
  end

  // Asynchronous read of the addressed field
  assign fif.field_q = mem[fif.addr];
endmodule : field_store

// file: core/field_access_top.sv
// Control-structure field access engine with an AHB-Lite register slave
//
// Functional notes
// - Error field untouched by exits; errors only
// - Long mode: encoding bits above 31 fail
// - Bits 14:13 select field width
// - Natural width is 64 or 32 bits
// - Bits 11:10 select field type
// - Bits 9:1 index within width/type
// - Bit 0 full or upper-half access
// - 16-bit read zero-extends bits 15:0
// - 16-bit write stores source bits 15:0
// - 32-bit read zero-extends, clears upper half
// - 32-bit write stores source bits 31:0
// - Full read outside long mode: low half
// - Full write outside long mode clears upper
// - Long mode full access moves 64 bits
// - High read returns upper half low
// - High write loads upper half
// - Pointed-to structures are not fields
//
// Register words: encoding low and high, source low and high, control,
// status, result low and high and the instruction-error field.
// Control holds the long-mode bit and two self-clearing go bits.
// Status shows busy, fail, done and a sticky exit flag cleared by a one.
// A go is taken only while the engine is idle; the access runs in the
// next cycle and its outcome can be read from the cycle after that.
// A refused access keeps the store and the result and records its cause.
// An exit sets its flag only; the instruction-error field is never touched.
// Unmapped words read zero and ignore writes; only address bits 7:0 decode.
`timescale 1ns/1ns
module field_access_top
  import csf_pkg::*;
#(
  parameter int IDX_W     = 3,    // Index bits backed by storage
  parameter bit HAS_EXT64 = 1'b1  // 64-bit extension present
) (
  // Clock and synchronous reset
  input  wire logic        CORE_CLK,
  input  wire logic        SYS_RST,
  // AHB-Lite slave port, zero wait states
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // Exit event from the core; sets the sticky flag only
  input  wire logic        VM_EXIT
);
  localparam int AW = IDX_W + 4;  // Store address width

  // Engine states: waiting for a go, or the one cycle that carries out the access
  typedef enum logic [0:0] {ST_IDLE, ST_EXEC} state_t;

  // Bus slave state
  // Write data comes one cycle after its address, so the offset is kept
  // for the data phase; read data is fetched at the address phase.
  logic        wr_pend_reg;   // Write data phase pending
  logic        wr_pend_next;
  logic [7:0]  wr_addr_reg;   // Address of the pending write
  logic [7:0]  wr_addr_next;
  logic [31:0] rdata_reg;     // Read data for the data phase
  logic [31:0] rdata_next;
  logic        rd_take;       // Read address phase accepted
  logic        wr_take;       // Write address phase accepted

  // Software-visible registers
  // Operand words only feed the decoder; a go uses what they hold then
  logic [31:0] enc_lo_reg;    // Encoding low word
  logic [31:0] enc_lo_next;
  logic [31:0] enc_hi_reg;    // Encoding high word
  logic [31:0] enc_hi_next;
  logic [31:0] src_lo_reg;    // Source low word
  logic [31:0] src_lo_next;
  logic [31:0] src_hi_reg;    // Source high word
  logic [31:0] src_hi_next;
  logic        long_reg;      // Long mode selected
  logic        long_next;
  // Results and flags written by the engine
  logic [63:0] res_reg;       // Last read result
  logic [63:0] res_next;
  logic [31:0] err_reg;       // Instruction-error field
  logic [31:0] err_next;
  logic        fail_reg;      // Last access refused
  logic        fail_next;
  logic        done_reg;      // Last access finished
  logic        done_next;
  logic        exit_reg;      // Exit seen, sticky
  logic        exit_next;

  // Access engine state
  // A go while the engine runs is dropped; it is busy for one cycle only
  state_t      state_reg;
  state_t      state_next;
  // Direction is latched with the go and used while executing
  logic        op_wr_reg;     // Current access is a write
  logic        op_wr_next;

  // Signals shared by the decoder and the store
  field_if #(.AW(AW)) fif ();

  // Decoder for the current encoding
  // Works on registered operands, so its outputs settle within the cycle
  field_decoder #(
    .IDX_W     (IDX_W),
    .HAS_EXT64 (HAS_EXT64)
  ) u_dec (
    .fif (fif.dec)
  );

  // Field word storage
  // Holds fields only; structures that fields point to are out of reach
  field_store #(
    .AW (AW)
  ) u_store (
    .clk (CORE_CLK),
    .rst (SYS_RST),
    .fif (fif.store)
  );

  // Register read multiplexer
  // Busy is passed in so a read that ends the execute cycle shows it
  function automatic logic [31:0] reg_read(input logic [7:0] a, input logic busy);
    logic [31:0] v;
    v = RST_WORD;
    case (a)
      OFF_ENC_LO: v = enc_lo_reg;
      OFF_ENC_HI: v = enc_hi_reg;
      OFF_SRC_LO: v = src_lo_reg;
      OFF_SRC_HI: v = src_hi_reg;
      // Go bits are not stored and read back as zero
      OFF_CTRL:   v = {31'h00000000, long_reg};
      OFF_STATUS: v = {28'h0000000, exit_reg, done_reg, fail_reg, busy};
      OFF_RES_LO: v = res_reg[31:0];
      OFF_RES_HI: v = res_reg[63:32];
      OFF_ERROR:  v = err_reg;
      default:    v = RST_WORD;  // Unmapped reads as zero
    endcase
    return v;
  endfunction : reg_read

  // Inputs to the decoder
  assign fif.enc_lo    = enc_lo_reg;
  assign fif.enc_hi    = enc_hi_reg;
  assign fif.src       = {src_hi_reg, src_lo_reg};
  // Long mode is forced off without the 64-bit extension
  assign fif.long_mode = long_reg & HAS_EXT64;
  assign fif.is_write  = op_wr_reg;
  assign fif.err_q     = err_reg;
  // Store written only by an accepted write access
  assign fif.we        = (state_reg == ST_EXEC) && op_wr_reg && !fif.fail;

  // Zero-wait slave, always OKAY
  // Every register answers in one cycle, so no wait state is needed
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign HRDATA    = rdata_reg;

  // Address phase acceptance
  // Taken only while selected, the bus is ready and a transfer is flagged
  assign rd_take = HSEL && HTRANS[1] && HREADY && !HWRITE;
  assign wr_take = HSEL && HTRANS[1] && HREADY && HWRITE;

  // Bus slave next state
  always_comb begin
    // A data phase follows every accepted write address
    wr_pend_next = wr_take;
    // Offset of the write, kept for its data phase
    wr_addr_next = wr_take ? HADDR[7:0] : wr_addr_reg;
    // Read data is captured now and stands until the next read
    rdata_next   = rd_take ? reg_read(HADDR[7:0], state_reg == ST_EXEC) : rdata_reg;
  end

  // Bus slave registers
  // Read data resets to zero so the bus shows zero before the first read
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rdata_reg   <= RST_WORD;
    end else begin
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      rdata_reg   <= rdata_next;
    end
  end

  // Register file and access engine next state
  always_comb begin
    // Everything holds unless written or changed by the engine
    enc_lo_next = enc_lo_reg;
    enc_hi_next = enc_hi_reg;
    src_lo_next = src_lo_reg;
    src_hi_next = src_hi_reg;
    long_next   = long_reg;
    res_next    = res_reg;
    err_next    = err_reg;
    fail_next   = fail_reg;
    done_next   = done_reg;
    exit_next   = exit_reg;
    state_next  = state_reg;
    op_wr_next  = op_wr_reg;
    // Software writes in the data phase
    if (wr_pend_reg) begin
      case (wr_addr_reg)
        // Operand words take the data phase value
        OFF_ENC_LO: enc_lo_next = HWDATA;
        OFF_ENC_HI: enc_hi_next = HWDATA;
        OFF_SRC_LO: src_lo_next = HWDATA;
        OFF_SRC_HI: src_hi_next = HWDATA;
        OFF_CTRL: begin
          long_next = HWDATA[CTRL_LONG];
          // Start a new access when idle; read wins over write
          if ((state_reg == ST_IDLE) && (HWDATA[CTRL_GO_RD] || HWDATA[CTRL_GO_WR])) begin
            state_next = ST_EXEC;
            op_wr_next = !HWDATA[CTRL_GO_RD];
            fail_next  = 1'b0;
            done_next  = 1'b0;
          end
        end
        OFF_STATUS: begin
          // Write one to clear the exit flag
          if (HWDATA[STAT_EXIT]) begin
            exit_next = 1'b0;
          end
        end
        default: begin
          // Read-only or unmapped, ignored
        end
      endcase
    end
    // Execute the access
    case (state_reg)
      ST_IDLE: begin
        // Waiting for a start
      end
      ST_EXEC: begin
        state_next = ST_IDLE;
        done_next  = 1'b1;
        if (fif.fail) begin
          // Refused: store and result keep their values
          fail_next = 1'b1;
          err_next  = fif.fail_code;
        end else if (!op_wr_reg) begin
          // Accepted read: latch the steered value
          res_next = fif.rd_val;
        end
        // An accepted write reaches the store through the write strobe
      end
      default: begin
        // Unused state code, back to idle
        state_next = ST_IDLE;
      end
    endcase
    // Exit sets the flag over a clear; error field left alone
    if (VM_EXIT) begin
      exit_next = 1'b1;
    end
  end

  // Register file and access engine registers
  // Reset clears every register, the instruction-error field included
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      enc_lo_reg <= RST_WORD;
      enc_hi_reg <= RST_WORD;
      src_lo_reg <= RST_WORD;
      src_hi_reg <= RST_WORD;
      long_reg   <= 1'b0;
      res_reg    <= RST_DWORD;
      err_reg    <= ERR_NONE;
      fail_reg   <= 1'b0;
      done_reg   <= 1'b0;
      exit_reg   <= 1'b0;
      state_reg  <= ST_IDLE;
      op_wr_reg  <= 1'b0;
    end else begin
      enc_lo_reg <= enc_lo_next;
      enc_hi_reg <= enc_hi_next;
      src_lo_reg <= src_lo_next;
      src_hi_reg <= src_hi_next;
      long_reg   <= long_next;
      res_reg    <= res_next;
      err_reg    <= err_next;
      fail_reg   <= fail_next;
      done_reg   <= done_next;
      exit_reg   <= exit_next;
      state_reg  <= state_next;
      op_wr_reg  <= op_wr_next;
    end
  end
endmodule : field_access_top

// file: tb/field_access_props.sv
// Bus-level checker for the field access engine
`timescale 1ns/1ns
module field_access_props
  import csf_pkg::*;
#(
  parameter int IDX_W     = 3,
  parameter bit HAS_EXT64 = 1'b1
) (
  input wire logic        CORE_CLK,
  input wire logic        SYS_RST,
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic [2:0]  HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  input wire logic        VM_EXIT
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  logic [7:0]  a_reg;                            // Data phase offset
  logic        v_reg, w_reg, gv_reg, ex_reg, ek_reg; // Phase, direction, go seen, exit, error known
  logic        xf_reg, xr_reg, xl_reg, xa_reg;   // Last go: fail, read, long, high access
  logic [1:0]  xw_reg, age_reg;                  // Last go width, cycles since go
  logic [31:0] lo_reg, hi_reg, ev_reg;           // Shadow encoding, last error seen
  wire rd = v_reg & !w_reg;
  wire wr = v_reg & w_reg;
  wire go = wr & (a_reg == OFF_CTRL) & (HWDATA[2] | HWDATA[1]);
  wire gl = HWDATA[0] & HAS_EXT64;
  wire fl = (gl & |hi_reg) | (|lo_reg[31:15]) | lo_reg[12] | (lo_reg[0] & (lo_reg[14:13] != WID_64))
          | (int'(lo_reg[9:1]) >= 2**IDX_W) | (!HWDATA[1] & (lo_reg[11:10] == TYP_RO));
  // Track bus phases and predict each access outcome
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      v_reg <= 1'b0;
      gv_reg <= 1'b0;
      ex_reg <= 1'b0;
      ek_reg <= 1'b1;
      ev_reg <= RST_WORD;
      age_reg <= 2'h3;
      lo_reg <= RST_WORD;
      hi_reg <= RST_WORD;
    end else begin
      v_reg <= HSEL & HTRANS[1] & HREADY;
      w_reg <= HWRITE;
      a_reg <= HADDR[7:0];
      if (wr && a_reg == OFF_ENC_LO) lo_reg <= HWDATA;
      if (wr && a_reg == OFF_ENC_HI) hi_reg <= HWDATA;
      if (go) begin
        gv_reg <= 1'b1;
        xf_reg <= fl;
        xr_reg <= HWDATA[1];
        xl_reg <= gl;
        xa_reg <= lo_reg[0];
        xw_reg <= lo_reg[14:13];
      end
      age_reg <= go ? 2'h0 : (age_reg == 2'h3 ? age_reg : age_reg + 2'h1);
      if (VM_EXIT) ex_reg <= 1'b1;
      else if (wr && a_reg == OFF_STATUS && HWDATA[STAT_EXIT]) ex_reg <= 1'b0;
      if (go) ek_reg <= 1'b0;
      else if (rd && a_reg == OFF_ERROR && age_reg >= 2'h2) begin
        ek_reg <= 1'b1;
        ev_reg <= HRDATA;
      end
    end
  end
  // Read data phase of one register
  sequence rd_s(logic [7:0] off);
    rd && a_reg == off;
  endsequence
  // Read data phase once the last go has settled
  sequence done_rd_s(logic [7:0] off);
    rd && a_reg == off && gv_reg && age_reg >= 2'h2;
  endsequence
  ready_okay_a: assert property (HREADYOUT && !HRESP)
    else $error("bus answer not ready or not OKAY");
  fail_flag_a: assert property (done_rd_s(OFF_STATUS) |-> HRDATA[STAT_FAIL] == xf_reg && HRDATA[STAT_DONE])
    else $error("status fail or done flag wrong");
  err_stable_a: assert property (rd && a_reg == OFF_ERROR && ek_reg && age_reg >= 2'h2 |-> HRDATA == ev_reg)
    else $error("error field changed without an access");
  res_hi_zero_a: assert property (done_rd_s(OFF_RES_HI) ##0 (xr_reg && !xf_reg &&
    (!xl_reg || xa_reg || xw_reg == WID_16 || xw_reg == WID_32)) |-> HRDATA == RST_WORD)
    else $error("upper result half not cleared");
  half_word_a: assert property (done_rd_s(OFF_RES_LO) ##0 (xr_reg && !xf_reg && xw_reg == WID_16)
    |-> HRDATA[31:16] == 16'h0000)
    else $error("short field read not zero extended");
  exit_sticky_a: assert property (rd_s(OFF_STATUS) ##0 (ex_reg && $past(ex_reg)) |-> HRDATA[STAT_EXIT])
    else $error("exit flag lost");
  ctrl_wo_a: assert property (rd_s(OFF_CTRL) |-> HRDATA[31:1] == 31'h0)
    else $error("go bits read back");
  unmapped_zero_a: assert property (rd && a_reg > OFF_ERROR |-> HRDATA == RST_WORD)
    else $error("unmapped read not zero");
endmodule : field_access_props

// file: tb/control_structure_field_access_tb_top.sv
// Self-checking bench for the field access engine
`timescale 1ns/1ns
module control_structure_field_access_tb_top import csf_pkg::*;;
  typedef struct {logic [7:0] a; logic [31:0] v; logic [31:0] m;} note_t;
  logic        CORE_CLK, SYS_RST, HSEL, HWRITE, HREADYOUT, HRESP, VM_EXIT;
  logic [31:0] HADDR, HWDATA, HRDATA;
  logic [1:0]  HTRANS;
  logic [2:0]  HSIZE;
  note_t       notes[$];         // Expected read results in bus order
  int          errors, n_compared;
  logic        dp_reg = 1'b0;    // Read data phase in progress
  logic [63:0] s1, s2;           // Random source operands
  logic [31:0] e;                // Encoding under test
  // One engine owns the structure and no guest runs: operands change only between accesses
  field_access_top #(.IDX_W(3), .HAS_EXT64(1'b1)) DUT (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .VM_EXIT(VM_EXIT));
  // Clock at 250 MHz
  initial begin
    CORE_CLK = 1'b0;
    forever #2 CORE_CLK = ~CORE_CLK;
  end
  // Compare each read data phase against the oldest note
  always @(posedge CORE_CLK) begin
    note_t n;
    if (dp_reg) begin
      n = notes.pop_front();
      n_compared++;
      if ((HRDATA & n.m) !== n.v) begin
        errors++;
        $display("Error reg %h expected %h seen %h", n.a, n.v, HRDATA & n.m);
      end
    end
    dp_reg <= HSEL & HTRANS[1] & HREADYOUT & !HWRITE & !SYS_RST;
  end
  task automatic close_out();
    $display("Compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  // One single bus transfer, address phase then data phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CORE_CLK);
    HTRANS <= 2'h2;
    HADDR <= {24'h000000, a};
    HWRITE <= w;
    do begin @(posedge CORE_CLK); end while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= d;
    do begin @(posedge CORE_CLK); end while (HREADYOUT !== 1'b1);
  endtask : xfer
  task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
    notes.push_back('{a, v & m, m});
    xfer(1'b0, a, 32'h00000000);
  endtask : rd
  function automatic logic [31:0] enc(input logic [1:0] w, input logic [1:0] t, input logic [8:0] i, input logic h);
    return {17'h00000, w, 1'b0, t, i, h};
  endfunction : enc
  // Load operands and launch one field access
  task automatic op(input logic [31:0] en, input logic [31:0] eh, input logic [63:0] s, input logic [2:0] c);
    xfer(1'b1, OFF_ENC_LO, en);
    xfer(1'b1, OFF_ENC_HI, eh);
    xfer(1'b1, OFF_SRC_LO, s[31:0]);
    xfer(1'b1, OFF_SRC_HI, s[63:32]);
    xfer(1'b1, OFF_CTRL, {29'h00000000, c});
  endtask : op
  // Check status, then the result on success
  task automatic chk(input logic [63:0] r, input logic f);
    rd(OFF_STATUS, f ? 32'h00000006 : 32'h00000004, 32'h00000006);
    if (!f) begin
      rd(OFF_RES_LO, r[31:0], 32'hFFFFFFFF);
      rd(OFF_RES_HI, r[63:32], 32'hFFFFFFFF);
    end
  endtask : chk
  // Refused access reports its cause
  task automatic bad(input logic [31:0] en, input logic [31:0] eh, input logic [31:0] code);
    op(en, eh, {$urandom, $urandom}, 3'h3);
    chk(64'h0, 1'b1);
    rd(OFF_ERROR, code, 32'hFFFFFFFF);
  endtask : bad
  // Watchdog
  initial begin
    #200000;
    errors++;
    close_out();
  end
  // Main sequence
  initial begin
    errors = 0;
    n_compared = 0;
    {SYS_RST, HSEL, HWRITE, VM_EXIT, HTRANS, HSIZE} = {4'h8, 2'h0, 3'h2};
    {HADDR, HWDATA} = 64'h0;
    void'($urandom(94));
    repeat (4) @(posedge CORE_CLK);
    SYS_RST <= 1'b0;
    HSEL <= 1'b1;
    for (int a = 0; a <= 36; a += 4) rd(a[7:0], 32'h00000000, 32'hFFFFFFFF);
    for (int w = 0; w < 4; w++) begin
      s1 = {$urandom, $urandom};
      op(enc(w[1:0], TYP_GUEST, 9'h001, 1'b0), 32'h0, s1, 3'h5);
      op(enc(w[1:0], TYP_GUEST, 9'h001, 1'b0), 32'h0, ~s1, 3'h3);
      chk(w == 0 ? {48'h0, s1[15:0]} : w == 2 ? {32'h0, s1[31:0]} : s1, 1'b0);
    end
    s1 = {$urandom, $urandom};
    s2 = {$urandom, $urandom};
    e = enc(WID_64, TYP_HOST, 9'h002, 1'b0);
    op(e, 32'h0, s2, 3'h5);
    op(e, 32'h0, s1, 3'h4);
    op(e, 32'h0, s2, 3'h3);
    chk({32'h0, s1[31:0]}, 1'b0);
    op(e | 32'h1, 32'h0, s2, 3'h4);
    op(e, 32'h0, s1, 3'h2);
    chk({32'h0, s1[31:0]}, 1'b0);
    op(e | 32'h1, 32'h0, s1, 3'h2);
    chk({32'h0, s2[31:0]}, 1'b0);
    op(e | 32'h1, 32'h0, s1, 3'h5);
    op(e, 32'h0, s2, 3'h3);
    chk({s1[31:0], s1[31:0]}, 1'b0);
    for (int t = 0; t < 4; t++) for (int i = 1; i < 3; i++) if (t != 1)
      op(enc(WID_32, t[1:0], i[8:0], 1'b0), 32'h0, {32'hFFFFFFFF, 32'(t * 16 + i)}, 3'h5);
    for (int t = 0; t < 4; t++) for (int i = 1; i < 3; i++) if (t != 1) begin
      op(enc(WID_32, t[1:0], i[8:0], 1'b0), 32'h0, 64'h0, 3'h3);
      chk({32'h0, 32'(t * 16 + i)}, 1'b0);
    end
    op(enc(WID_32, TYP_RO, 9'h001, 1'b0), 32'h0, 64'h5, 3'h5);
    chk(64'h0, 1'b1);
    rd(OFF_ERROR, ERR_RD_ONLY, 32'hFFFFFFFF);
    e = enc(WID_32, TYP_GUEST, 9'h001, 1'b0);
    bad(e, 32'h1, ERR_ENC_HIGH);
    bad(e | 32'h8000, 32'h0, ERR_BAD_FLD);
    bad(e | 32'h1000, 32'h0, ERR_BAD_FLD);
    bad(e | 32'h1, 32'h0, ERR_BAD_FLD);
    bad(enc(WID_32, TYP_GUEST, 9'h008, 1'b0), 32'h0, ERR_BAD_FLD);
    op(e, 32'h1, 64'h0, 3'h2);
    chk(64'h21, 1'b0);
    op(enc(WID_32, TYP_RO, 9'h000, 1'b0), 32'h0, 64'h0, 3'h2);
    chk({32'h0, ERR_BAD_FLD}, 1'b0);
    rd(OFF_ERROR, ERR_BAD_FLD, 32'hFFFFFFFF);
    @(posedge CORE_CLK);
    VM_EXIT <= 1'b1;
    repeat (2) @(posedge CORE_CLK);
    VM_EXIT <= 1'b0;
    rd(OFF_STATUS, 32'h00000008, 32'h00000008);
    rd(OFF_ERROR, ERR_BAD_FLD, 32'hFFFFFFFF);
    xfer(1'b1, OFF_STATUS, 32'h00000008);
    rd(OFF_STATUS, 32'h00000000, 32'h00000008);
    repeat (3) @(posedge CORE_CLK);
    close_out();
  end
endmodule : control_structure_field_access_tb_top
bind field_access_top field_access_props #(.IDX_W(IDX_W), .HAS_EXT64(HAS_EXT64)) u_props (
  .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .VM_EXIT(VM_EXIT));
